// file: rtl/agt_pkg.sv
// Constants and types shared by the bus agent
package agt_pkg;
  // Bus commands decoded or issued
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  // Memory window claimed as target; value is arbitrary
  localparam logic [63:0] TGT_BASE = 64'h0000_0000_8000_0000;
  localparam int TGT_ADDR_LSB = 5;
  localparam int WORD_LSB = 3;
  localparam int WORD_BITS = 2;
  localparam int TGT_WORDS = 4;
  // Idle clocks seen before taking the bus, clocks before abort
  localparam logic [1:0] IDLE_CLKS = 2'h2;
  localparam logic [2:0] ABORT_CLKS = 3'h5;
  // Completion status codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_STOP = 2'h1;
  localparam logic [1:0] ST_ABORT = 2'h2;
  // Reset values of pins
  localparam logic [7:0] CBE_IDLE = 8'hFF;
  localparam logic [63:0] AD_IDLE = 64'h0;
  typedef enum logic [2:0] {
    S_IDLE, S_M_ADDR, S_M_DATA, S_T_DEV, S_T_DATA, S_TURN
  } bus_state_t;
endpackage : agt_pkg

// file: rtl/pci_agent.sv
// Master and target bus agent with core-side request port
// Contract
// - A sustained line driven low is driven high one clock before release.
// - Take over a sustained line only one clock after its release.
// - During bus reset every bus output floats.
// - Address phase is the first clock with frame low.
// - Address phase carries the 64-bit address on the data lines.
// - Byte lane 0 is the least significant byte, lane 7 the most.
// - On a 32-bit bus the upper lanes stay out of the cycle.
// - Command in address phase, active-low byte enables in data phases.
// - Low parity makes low lanes plus enables plus parity even.
// - High parity makes high lanes plus enables plus parity even.
// - Parity valid one clock after address or data is driven.
// - Parity held until one clock after the data phase ends.
// - Master drives parity for address and writes, target for reads.
// - Master asserts frame to start and deasserts it in last phase.
// - Data phase ends when both ready lines are sampled low.
// - Master drives initiator-ready; target only samples it.
// - Target drives target-ready; master only samples it.
// - Target asks stop; master ends its cycle on stop.
// - Init select is the chip select of configuration cycles.
// - Target claims with device-select; master watches it.
// - Address parity error pulses system error for one clock.
// - Data parity error drives parity error two clocks later.
// - 64-bit request has frame timing, acknowledge device-select timing.
module pci_agent (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic wr,
  input wire logic [3:0] cmd,
  input wire logic [63:0] addr,
  input wire logic [63:0] wdata,
  input wire logic [7:0] be,
  input wire logic wide,
  output logic busy,
  output logic done,
  output logic [63:0] rdata,
  output logic [1:0] status,
  input wire logic pci_clk,
  input wire logic bus_rst_n,
  input wire logic [63:0] ad_in,
  output logic [63:0] ad_out,
  output logic [1:0] ad_oe,
  input wire logic [7:0] cbe_n_in,
  output logic [7:0] cbe_n_out,
  output logic [1:0] cbe_oe,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe,
  input wire logic par64_in,
  output logic par64_out,
  output logic par64_oe,
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_oe,
  input wire logic irdy_n_in,
  output logic irdy_n_out,
  output logic irdy_oe,
  input wire logic trdy_n_in,
  output logic trdy_n_out,
  output logic trdy_oe,
  input wire logic stop_n_in,
  output logic stop_n_out,
  output logic stop_oe,
  input wire logic devsel_n_in,
  output logic devsel_n_out,
  output logic devsel_oe,
  input wire logic req64_n_in,
  output logic req64_n_out,
  output logic req64_oe,
  input wire logic ack64_n_in,
  output logic ack64_n_out,
  output logic ack64_oe,
  input wire logic perr_n_in,
  output logic perr_n_out,
  output logic perr_oe,
  output logic serr_n_out,
  output logic serr_oe,
  input wire logic idsel
);
  logic req_tgl_reg, req_wr_reg, req_wide_reg;
  logic [3:0] req_cmd_reg;
  logic [7:0] req_be_reg;
  logic [63:0] req_addr_reg, req_wdata_reg;
  logic done_s1_reg, done_s2_reg, done_seen_reg;
  logic rst_s1_reg, rst_s2_reg, brst_s1_reg, brst_s2_reg, brst_reg;
  logic req_s1_reg, req_s2_reg, taken_reg, done_tgl_reg;
  logic [63:0] res_rdata_reg;
  logic [1:0] res_status_reg;
  agt_pkg::bus_state_t state_reg;
  logic frame_prev_reg, m_dev_reg, m_ack_reg;
  logic t_wr_reg, t_wide_reg;
  logic [1:0] t_idx_reg, idle_cnt_reg, perr_st_reg;
  logic [2:0] abort_cnt_reg;
  logic a_chk_reg, a_exp_reg, d_chk_reg, d_exp_reg, d_exp64_reg;
  logic d_wide_reg, perr_pend_reg;
  logic [63:0] mem [agt_pkg::TGT_WORDS];
  logic [7:0] cbe_w;
  logic addr_phase, t_hit, pending, m_abort, m_wide_ok;
  logic t_wr_done, rx_done, rx_wide;

  // Even parity over one half: data lanes and enables
  function automatic logic par_f(input logic [31:0] d, input logic [3:0] c);
    par_f = ^{d, c};
  endfunction : par_f

  // Own memory window or configuration cycle with select
  function automatic logic hit_f(input logic [3:0] c, input logic [63:0] a,
                                 input logic sel);
    hit_f = ((c == agt_pkg::CMD_MEM_RD || c == agt_pkg::CMD_MEM_WR) &&
             a[63:agt_pkg::TGT_ADDR_LSB] ==
             agt_pkg::TGT_BASE[63:agt_pkg::TGT_ADDR_LSB]) ||
            ((c == agt_pkg::CMD_CFG_RD || c == agt_pkg::CMD_CFG_WR) &&
             sel && a[1:0] == 2'h0);
  endfunction : hit_f

  // Core request capture; fields stay still until done comes back
  always_ff @(posedge clk) begin
    if (reset) begin
      req_tgl_reg <= 1'h0;
      req_wr_reg <= 1'h0;
      req_wide_reg <= 1'h0;
      req_cmd_reg <= 4'h0;
      req_be_reg <= 8'h00;
      req_addr_reg <= 64'h0;
      req_wdata_reg <= 64'h0;
      done_seen_reg <= 1'h0;
      busy <= 1'h0;
      done <= 1'h0;
      rdata <= 64'h0;
      status <= agt_pkg::ST_OK;
    end else begin
      done <= 1'h0;
      if (start && !busy) begin
        req_tgl_reg <= ~req_tgl_reg;
        req_wr_reg <= wr;
        req_wide_reg <= wide;
        req_cmd_reg <= cmd;
        req_be_reg <= be;
        req_addr_reg <= addr;
        req_wdata_reg <= wdata;
        busy <= 1'h1;
      end else if (done_s2_reg != done_seen_reg) begin
        done_seen_reg <= done_s2_reg;
        busy <= 1'h0;
        done <= 1'h1;
        rdata <= res_rdata_reg;
        status <= res_status_reg;
      end
    end
  end

  // Done toggle into the core clock
  always_ff @(posedge clk) begin
    if (reset) begin
      done_s1_reg <= 1'h0;
      done_s2_reg <= 1'h0;
    end else begin
      done_s1_reg <= done_tgl_reg;
      done_s2_reg <= done_s1_reg;
    end
  end

  // Resets and request toggle into the bus clock
  always_ff @(posedge pci_clk) begin
    rst_s1_reg <= reset;
    rst_s2_reg <= rst_s1_reg;
    brst_s1_reg <= bus_rst_n;
    brst_s2_reg <= brst_s1_reg;
    brst_reg <= rst_s2_reg | ~brst_s2_reg;
    req_s1_reg <= req_tgl_reg;
    req_s2_reg <= req_s1_reg;
  end

  // Lane values on the wire and phase events
  always_comb begin
    cbe_w[3:0] = cbe_oe[0] ? cbe_n_out[3:0] : cbe_n_in[3:0];
    cbe_w[7:4] = cbe_oe[1] ? cbe_n_out[7:4] : cbe_n_in[7:4];
    addr_phase = frame_prev_reg && !frame_n_in &&
                 state_reg == agt_pkg::S_IDLE;
    t_hit = addr_phase && hit_f(cbe_n_in[3:0], ad_in, idsel);
    pending = req_s2_reg != taken_reg;
    m_abort = devsel_n_in && !m_dev_reg &&
              abort_cnt_reg == agt_pkg::ABORT_CLKS;
    m_wide_ok = m_ack_reg || !ack64_n_in;
    t_wr_done = state_reg == agt_pkg::S_T_DATA && !irdy_n_in && t_wr_reg;
    rx_done = t_wr_done || (state_reg == agt_pkg::S_M_DATA &&
              !trdy_n_in && !req_wr_reg);
    rx_wide = state_reg == agt_pkg::S_T_DATA ? t_wide_reg : m_wide_ok;
  end

  // Idle count; our own drive never counts as idle
  always_ff @(posedge pci_clk) begin
    frame_prev_reg <= frame_n_in;
    if (brst_reg || frame_oe || irdy_oe || !frame_n_in || !irdy_n_in) begin
      idle_cnt_reg <= 2'h0;
    end else if (idle_cnt_reg != agt_pkg::IDLE_CLKS) begin
      idle_cnt_reg <= idle_cnt_reg + 2'h1;
    end
  end

  // Bus sequencer: master and target ends share the pins
  always_ff @(posedge pci_clk) begin
    if (brst_reg) begin
      state_reg <= agt_pkg::S_IDLE;
      {frame_n_out, irdy_n_out, trdy_n_out, stop_n_out} <= 4'hF;
      {devsel_n_out, req64_n_out, ack64_n_out} <= 3'h7;
      {frame_oe, irdy_oe, trdy_oe, stop_oe} <= 4'h0;
      {devsel_oe, req64_oe, ack64_oe} <= 3'h0;
      ad_out <= agt_pkg::AD_IDLE;
      ad_oe <= 2'h0;
      cbe_n_out <= agt_pkg::CBE_IDLE;
      cbe_oe <= 2'h0;
      // Toggles follow core reset only; a bus reset alone
      // must not replay a request or fake a completion
      if (rst_s2_reg) begin
        taken_reg <= 1'h0;
        done_tgl_reg <= 1'h0;
      end
      res_rdata_reg <= 64'h0;
      res_status_reg <= agt_pkg::ST_OK;
      {m_dev_reg, m_ack_reg, t_wr_reg, t_wide_reg} <= 4'h0;
      t_idx_reg <= 2'h0;
      abort_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        agt_pkg::S_IDLE: begin
          {frame_oe, irdy_oe, trdy_oe, stop_oe} <= 4'h0;
          {devsel_oe, req64_oe, ack64_oe} <= 3'h0;
          ad_oe <= 2'h0;
          cbe_oe <= 2'h0;
          if (t_hit) begin
            t_wr_reg <= cbe_n_in[0];
            t_wide_reg <= !req64_n_in;
            t_idx_reg <= ad_in[agt_pkg::WORD_LSB +: agt_pkg::WORD_BITS];
            devsel_n_out <= 1'h0;
            devsel_oe <= 1'h1;
            {trdy_oe, stop_oe} <= 2'h3;
            ack64_n_out <= req64_n_in;
            ack64_oe <= 1'h1;
            state_reg <= agt_pkg::S_T_DEV;
          end else if (pending && idle_cnt_reg == agt_pkg::IDLE_CLKS) begin
            taken_reg <= ~taken_reg;
            frame_n_out <= 1'h0;
            {frame_oe, irdy_oe} <= 2'h3;
            req64_n_out <= ~req_wide_reg;
            req64_oe <= 1'h1;
            ad_out <= req_addr_reg;
            ad_oe <= {req_wide_reg, 1'h1};
            cbe_n_out <= {req_cmd_reg, req_cmd_reg};
            cbe_oe <= {req_wide_reg, 1'h1};
            {m_dev_reg, m_ack_reg} <= 2'h0;
            abort_cnt_reg <= 3'h0;
            state_reg <= agt_pkg::S_M_ADDR;
          end
        end
        agt_pkg::S_M_ADDR: begin
          frame_n_out <= 1'h1;
          irdy_n_out <= 1'h0;
          req64_n_out <= 1'h1;
          ad_out <= req_wdata_reg;
          ad_oe <= req_wr_reg ? {req_wide_reg, 1'h1} : 2'h0;
          cbe_n_out <= ~req_be_reg;
          state_reg <= agt_pkg::S_M_DATA;
        end
        agt_pkg::S_M_DATA: begin
          abort_cnt_reg <= abort_cnt_reg + 3'h1;
          if (!devsel_n_in) m_dev_reg <= 1'h1;
          if (!ack64_n_in) m_ack_reg <= 1'h1;
          if (!devsel_n_in && ack64_n_in) begin
            ad_oe[1] <= 1'h0;
            cbe_oe[1] <= 1'h0;
          end
          // end on ready, stop or abort
          if (!trdy_n_in || !stop_n_in || m_abort) begin
            done_tgl_reg <= ~done_tgl_reg;
            res_rdata_reg <= {m_wide_ok ? ad_in[63:32] : 32'h0, ad_in[31:0]};
            res_status_reg <= !trdy_n_in ? agt_pkg::ST_OK :
                              !stop_n_in ? agt_pkg::ST_STOP :
                              agt_pkg::ST_ABORT;
            irdy_n_out <= 1'h1;
            ad_oe <= 2'h0;
            cbe_oe <= 2'h0;
            state_reg <= agt_pkg::S_TURN;
          end
        end
        agt_pkg::S_T_DEV: begin
          trdy_n_out <= 1'h0;
          stop_n_out <= 1'h0;
          ad_out <= mem[t_idx_reg];
          ad_oe <= t_wr_reg ? 2'h0 : {t_wide_reg, 1'h1};
          state_reg <= agt_pkg::S_T_DATA;
        end
        agt_pkg::S_T_DATA: begin
          if (!irdy_n_in) begin
            {devsel_n_out, trdy_n_out, stop_n_out} <= 3'h7;
            ack64_n_out <= 1'h1;
            ad_oe <= 2'h0;
            state_reg <= agt_pkg::S_TURN;
          end
        end
        default: begin
          state_reg <= agt_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Target scratch words
  always_ff @(posedge pci_clk) begin
    if (t_wr_done) begin
      for (int i = 0; i < 8; i++) begin
        if (!cbe_n_in[i] && (i < 4 || t_wide_reg)) begin
          mem[t_idx_reg][8 * i +: 8] <= ad_in[8 * i +: 8];
        end
      end
    end
  end

  // Parity trails the lanes it covers by one clock
  always_ff @(posedge pci_clk) begin
    if (brst_reg) begin
      {par_out, par_oe, par64_out, par64_oe} <= 4'h0;
    end else begin
      par_out <= par_f(ad_out[31:0], cbe_w[3:0]);
      par_oe <= ad_oe[0];
      par64_out <= par_f(ad_out[63:32], cbe_w[7:4]);
      par64_oe <= ad_oe[1];
    end
  end

  // Parity checks and error lines
  always_ff @(posedge pci_clk) begin
    if (brst_reg) begin
      {a_chk_reg, a_exp_reg, d_chk_reg, d_exp_reg} <= 4'h0;
      {d_exp64_reg, d_wide_reg, perr_pend_reg} <= 3'h0;
      perr_st_reg <= 2'h0;
      perr_n_out <= 1'h1;
      perr_oe <= 1'h0;
      serr_n_out <= 1'h0;
      serr_oe <= 1'h0;
    end else begin
      a_chk_reg <= addr_phase;
      a_exp_reg <= par_f(ad_in[31:0], cbe_n_in[3:0]);
      serr_oe <= a_chk_reg && par_in != a_exp_reg;
      d_chk_reg <= rx_done;
      d_wide_reg <= rx_wide;
      d_exp_reg <= par_f(ad_in[31:0], cbe_n_in[3:0]);
      d_exp64_reg <= par_f(ad_in[63:32], cbe_n_in[7:4]);
      perr_pend_reg <= d_chk_reg && (par_in != d_exp_reg ||
                       (d_wide_reg && par64_in != d_exp64_reg));
      case (perr_st_reg)
        2'h0: begin
          if (perr_pend_reg) begin
            perr_n_out <= 1'h0;
            perr_oe <= 1'h1;
            perr_st_reg <= 2'h1;
          end
        end
        2'h1: begin
          perr_n_out <= 1'h1;
          perr_st_reg <= 2'h2;
        end
        default: begin
          perr_oe <= 1'h0;
          perr_st_reg <= 2'h0;
        end
      endcase
    end
  end

  default clocking cb @(posedge pci_clk); endclocking
  default disable iff (brst_reg);

  sequence m_addr_s;
    state_reg == agt_pkg::S_M_ADDR && !frame_n_out;
  endsequence
  sequence m_last_s;
    frame_n_out && !irdy_n_out && frame_oe && irdy_oe;
  endsequence
  sequence rx_bad_s;
    rx_done ##1 (par_in != d_exp_reg);
  endsequence

  frame_release_a:
    assert property ($fell(frame_oe) |-> $past(frame_n_out))
    else $error("frame released while low");
  devsel_release_a:
    assert property ($fell(devsel_oe) |-> $past(devsel_n_out) && !devsel_oe)
    else $error("devsel released while low");
  idle_gap_a:
    assert property ($rose(frame_oe) |-> $past(idle_cnt_reg) == 2'h2)
    else $error("bus taken without idle gap");
  reset_float_a:
    assert property (disable iff (1'h0) brst_reg |=> ad_oe == 2'h0 &&
                     !frame_oe && !devsel_oe && !perr_oe && !trdy_oe)
    else $error("bus driven during reset");
  low_parity_a:
    assert property (par_oe |-> (^{par_out, $past(ad_out[31:0]),
                     $past(cbe_w[3:0])}) == 1'h0)
    else $error("low parity odd");
  high_parity_a:
    assert property (par64_oe |-> (^{par64_out, $past(ad_out[63:32]),
                     $past(cbe_w[7:4])}) == 1'h0)
    else $error("high parity odd");
  parity_lag_a:
    assert property ($rose(ad_oe[0]) |-> !par_oe ##1 par_oe)
    else $error("parity not one clock late");
  narrow_lanes_a:
    assert property (state_reg == agt_pkg::S_M_DATA && !devsel_n_in &&
                     ack64_n_in |=> !ad_oe[1] && !cbe_oe[1])
    else $error("upper lanes on narrow target");
  last_phase_a:
    assert property (m_addr_s |=> m_last_s)
    else $error("frame not raised in final phase");
  master_stop_a:
    assert property (state_reg == agt_pkg::S_M_DATA && !stop_n_in
                     |=> state_reg == agt_pkg::S_TURN && irdy_n_out)
    else $error("master ignored stop");
  claim_a:
    assert property (t_hit |=> !devsel_n_out && devsel_oe ##1 !trdy_n_out)
    else $error("own address not claimed");
  serr_pulse_a:
    assert property (a_chk_reg && par_in != a_exp_reg |=> serr_oe ##1 !serr_oe)
    else $error("system error not one clock");
  perr_timing_a:
    assert property (rx_bad_s |=> ##1 (perr_oe && !perr_n_out) ##1 perr_n_out)
    else $error("parity error late or missing");
endmodule : pci_agent

// file: verification/bus_part.sv
// Far-side bus agent model: slow target and plain master
module bus_part #(
  parameter logic [63:0] RD_WORD = 64'h0
) (
  input wire logic pci_clk,
  input wire logic [63:0] ad_in,
  input wire logic [7:0] cbe_n_in,
  input wire logic par_in,
  input wire logic par64_in,
  input wire logic frame_n_in,
  input wire logic trdy_n_in,
  input wire logic devsel_n_in,
  input wire logic req64_n_in,
  input wire logic [1:0] t_mode,
  output logic [63:0] p_ad,
  output logic [1:0] p_ad_oe,
  output logic [3:0] p_cbe,
  output logic p_par,
  output logic p_par64,
  output logic p_par_oe,
  output logic p_frame_n,
  output logic p_irdy_n,
  output logic p_m_oe,
  output logic p_trdy_n,
  output logic p_stop_n,
  output logic p_devsel_n,
  output logic p_ack64_n,
  output logic p_t_oe,
  output logic idsel
);
  logic [63:0] cap_addr;
  logic [63:0] cap_data;
  logic [3:0] cap_cmd;
  logic [7:0] cap_be;
  logic r64;
  logic rd_cyc;
  int par_err;

  // Idle: nothing driven, lines left to the pull-ups
  initial begin
    {p_ad_oe, p_par_oe, p_m_oe, p_t_oe, idsel} = '0;
    {p_frame_n, p_irdy_n, p_trdy_n, p_stop_n, p_devsel_n, p_ack64_n} = '1;
    {p_ad, p_cbe, p_par, p_par64} = '0;
    par_err = 0;
  end

  // Target: claim, one wait state, then ready or stop
  always begin
    @(posedge pci_clk);
    if (!frame_n_in && !p_m_oe && t_mode != 2'h0) begin
      cap_addr = ad_in;
      cap_cmd = cbe_n_in[3:0];
      rd_cyc = cap_cmd == agt_pkg::CMD_MEM_RD;
      r64 = !req64_n_in && t_mode == 2'h1;
      p_t_oe <= 1'b1;
      p_devsel_n <= 1'b0;
      p_ack64_n <= !r64;
      @(posedge pci_clk);
      if (par_in !== ^{cap_addr[31:0], cap_cmd}) par_err++;
      if (t_mode == 2'h3) p_stop_n <= 1'b0;
      else p_trdy_n <= 1'b0;
      p_ad <= RD_WORD;
      p_ad_oe <= {r64 & rd_cyc, rd_cyc};
      @(posedge pci_clk);
      cap_data = ad_in;
      cap_be = cbe_n_in;
      if (!rd_cyc && par_in !== ^{ad_in[31:0], cbe_n_in[3:0]})
        par_err++;
      if (!rd_cyc && r64 && par64_in !== ^{ad_in[63:32], cbe_n_in[7:4]})
        par_err++;
      p_par <= ^{RD_WORD[31:0], cbe_n_in[3:0]};
      p_par64 <= ^{RD_WORD[63:32], cbe_n_in[7:4]};
      p_par_oe <= rd_cyc;
      {p_trdy_n, p_stop_n, p_devsel_n, p_ack64_n} <= 4'hF;
      p_ad_oe <= 2'h0;
      @(posedge pci_clk);
      p_t_oe <= 1'b0;
      p_par_oe <= 1'b0;
    end
  end

  // Master: one 32-bit data phase; bad[0] address, bad[1] data parity
  task automatic mst(input logic [3:0] cmd, input logic [63:0] a,
      input logic [31:0] d, input logic sel, input logic [1:0] bad,
      output logic [31:0] rd, output logic hit);
    int n;
    hit = 1'b0;
    @(posedge pci_clk);
    {p_m_oe, p_frame_n, p_irdy_n, p_ad_oe} <= 5'b10111;
    p_ad <= a;
    p_cbe <= cmd;
    idsel <= sel;
    @(posedge pci_clk);
    {p_frame_n, p_irdy_n, p_cbe, p_par_oe} <= 7'b1000001;
    p_ad <= {32'h0, d};
    p_ad_oe <= {1'b0, cmd[0]};
    p_par <= ^{a[31:0], cmd} ^ bad[0];
    @(posedge pci_clk);
    p_par <= ^d ^ bad[1];
    p_par_oe <= cmd[0];
    for (n = 0; n < 6; n++) begin
      if (!devsel_n_in) hit = 1'b1;
      if (!trdy_n_in) break;
      @(posedge pci_clk);
    end
    rd = ad_in[31:0];
    p_irdy_n <= 1'b1;
    p_ad_oe <= 2'h0;
    @(posedge pci_clk);
    {p_m_oe, p_par_oe, idsel} <= 3'b000;
    if (!cmd[0] && hit && par_in !== ^{rd, 4'h0}) par_err++;
  endtask : mst
endmodule : bus_part

// file: verification/test_pci_bus_agent_signalling.sv
// Bench for the bus agent against a far-side agent model
module test_pci_bus_agent_signalling;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] RD_WORD = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] TB = agt_pkg::TGT_BASE;
  logic clk, reset, start, wr, wide, pci_clk, bus_rst_n, idsel;
  logic [3:0] cmd, p_cbe;
  logic [63:0] addr, wdata, rdata, ad_out, p_ad, flt, ad_in;
  logic [7:0] be, cbe_n_out, cbe_n_in;
  logic [1:0] status, ad_oe, cbe_oe, p_ad_oe, t_mode;
  logic busy, done, par_out, par_oe, par64_out, par64_oe, frame_n_out,
    frame_oe, irdy_n_out, irdy_oe, trdy_n_out, trdy_oe, stop_n_out, stop_oe,
    devsel_n_out, devsel_oe, req64_n_out, req64_oe, ack64_n_out, ack64_oe,
    perr_n_out, perr_oe, serr_n_out, serr_oe;
  logic p_par, p_par64, p_par_oe, p_frame_n, p_irdy_n, p_m_oe, p_trdy_n,
    p_stop_n, p_devsel_n, p_ack64_n, p_t_oe;
  logic par_in, par64_in, frame_n_in, irdy_n_in, trdy_n_in, stop_n_in,
    devsel_n_in, req64_n_in, ack64_n_in, perr_n_in;
  logic [5:0] sus_oe, sus_v, prev_oe, prev_v;
  int errors, checks_done, serr_cnt, perr_cnt;

  // Wire levels: enabled driver wins, controls pull up, data floats
  assign frame_n_in = frame_oe ? frame_n_out : (p_m_oe ? p_frame_n : 1'b1);
  assign irdy_n_in = irdy_oe ? irdy_n_out : (p_m_oe ? p_irdy_n : 1'b1);
  assign trdy_n_in = trdy_oe ? trdy_n_out : (p_t_oe ? p_trdy_n : 1'b1);
  assign stop_n_in = stop_oe ? stop_n_out : (p_t_oe ? p_stop_n : 1'b1);
  assign devsel_n_in = devsel_oe ? devsel_n_out : (p_t_oe ? p_devsel_n : 1'b1);
  assign ack64_n_in = ack64_oe ? ack64_n_out : (p_t_oe ? p_ack64_n : 1'b1);
  assign req64_n_in = req64_oe ? req64_n_out : 1'b1;
  assign perr_n_in = perr_oe ? perr_n_out : 1'b1;
  assign par_in = par_oe ? par_out : (p_par_oe ? p_par : flt[0]);
  assign par64_in = par64_oe ? par64_out : (p_par_oe ? p_par64 : flt[1]);
  assign ad_in[31:0] = ad_oe[0] ? ad_out[31:0] :
    (p_ad_oe[0] ? p_ad[31:0] : flt[31:0]);
  assign ad_in[63:32] = ad_oe[1] ? ad_out[63:32] :
    (p_ad_oe[1] ? p_ad[63:32] : flt[63:32]);
  assign cbe_n_in[3:0] = cbe_oe[0] ? cbe_n_out[3:0] : (p_m_oe ? p_cbe : 4'hF);
  assign cbe_n_in[7:4] = cbe_oe[1] ? cbe_n_out[7:4] : 4'hF;
  assign sus_oe = {frame_oe, irdy_oe, trdy_oe, stop_oe, devsel_oe, perr_oe};
  assign sus_v = {frame_n_out, irdy_n_out, trdy_n_out, stop_n_out,
    devsel_n_out, perr_n_out};

  pci_agent u_dut (.*);
  bus_part #(.RD_WORD(RD_WORD)) u_part (.*);

  // Core and link clocks, unrelated in phase
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    pci_clk = 1'b0;
    #3;
    forever #6 pci_clk = ~pci_clk;
  end

  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Wire watch: error pulses, release level, no two drivers
  always @(posedge pci_clk) begin
    flt <= ~flt;
    if (serr_oe === 1'b1) serr_cnt++;
    if (perr_n_in === 1'b0) perr_cnt++;
    if (|(prev_oe & ~sus_oe & ~prev_v)) check("release high", 0, 1);
    if ((frame_oe & p_m_oe) | (trdy_oe & p_t_oe) | (ad_oe[0] & p_ad_oe[0]))
      check("one driver", 0, 1);
    prev_oe <= sus_oe;
    prev_v <= sus_v;
  end

  // Core request, waits for the completion pulse
  task automatic req(input logic w, input logic [3:0] c,
      input logic [63:0] a, input logic [63:0] d, input logic [7:0] b,
      input logic wd);
    int n;
    @(negedge clk);
    {start, wr, cmd, addr, wdata, be, wide} = {1'b1, w, c, a, d, b, wd};
    @(negedge clk);
    start = 1'b0;
    check("busy", busy, 1);
    for (n = 0; n < 100 && done !== 1'b1; n++) @(negedge clk);
    check("done", done, 1);
    check("busy low", busy, 0);
    check("far parity", u_part.par_err, 0);
  endtask : req

  task automatic t_mwr;
    t_mode = 2'h1;
    req(1, agt_pkg::CMD_MEM_WR, 64'h1234_5678_9ABC_DEF0,
      64'h0807_0605_0403_0201, 8'h5A, 1);
    check("status", status, agt_pkg::ST_OK);
    check("address", u_part.cap_addr, 64'h1234_5678_9ABC_DEF0);
    check("command", u_part.cap_cmd, agt_pkg::CMD_MEM_WR);
    check("wdata", u_part.cap_data, 64'h0807_0605_0403_0201);
    check("enables", u_part.cap_be, 8'hA5);
    $display("master write done");
  endtask : t_mwr

  task automatic t_mrd;
    t_mode = 2'h1;
    req(0, agt_pkg::CMD_MEM_RD, 64'h40, 64'h0, 8'hFF, 1);
    check("rdata wide", rdata, RD_WORD);
    t_mode = 2'h2;
    req(0, agt_pkg::CMD_MEM_RD, 64'h48, 64'h0, 8'hFF, 1);
    check("rdata narrow", rdata, {32'h0, RD_WORD[31:0]});
    check("perr quiet", perr_cnt, 0);
    $display("master read done");
  endtask : t_mrd

  task automatic t_mend;
    t_mode = 2'h3;
    req(1, agt_pkg::CMD_MEM_WR, 64'h80, 64'h1, 8'h0F, 0);
    check("stop status", status, agt_pkg::ST_STOP);
    t_mode = 2'h0;
    req(0, agt_pkg::CMD_MEM_RD, 64'h80, 64'h0, 8'h0F, 0);
    check("abort status", status, agt_pkg::ST_ABORT);
    $display("master stop and abort done");
  endtask : t_mend

  task automatic t_tgt;
    logic [31:0] rd;
    logic hit;
    t_mode = 2'h0;
    u_part.mst(agt_pkg::CMD_MEM_WR, TB + 64'h8, 32'hCAFE_F00D, 0, 0, rd, hit);
    check("claim", hit, 1);
    u_part.mst(agt_pkg::CMD_MEM_RD, TB + 64'h8, 32'h0, 0, 0, rd, hit);
    check("read back", rd, 32'hCAFE_F00D);
    u_part.mst(agt_pkg::CMD_CFG_RD, 64'h8, 32'h0, 1, 0, rd, hit);
    check("cfg alias", rd, 32'hCAFE_F00D);
    u_part.mst(agt_pkg::CMD_CFG_RD, 64'h8, 32'h0, 0, 0, rd, hit);
    check("cfg unselected", hit, 0);
    check("read parity", u_part.par_err, 0);
    $display("target done");
  endtask : t_tgt

  task automatic t_perr;
    logic [31:0] rd;
    logic hit;
    int s0;
    int p0;
    s0 = serr_cnt;
    p0 = perr_cnt;
    u_part.mst(agt_pkg::CMD_MEM_WR, TB, 32'h1, 0, 2'h2, rd, hit);
    repeat (3) @(posedge pci_clk);
    check("perr clocks", perr_cnt - p0, 1);
    u_part.mst(agt_pkg::CMD_MEM_WR, TB, 32'h1, 0, 2'h1, rd, hit);
    repeat (3) @(posedge pci_clk);
    check("serr clocks", serr_cnt - s0, 1);
    $display("parity error done");
  endtask : t_perr

  task automatic t_reset;
    @(negedge clk);
    bus_rst_n = 1'b0;
    repeat (4) @(posedge pci_clk);
    #1;
    check("float", {ad_oe, cbe_oe, par_oe, par64_oe, sus_oe, req64_oe,
      ack64_oe, serr_oe}, 0);
    @(negedge clk);
    bus_rst_n = 1'b1;
    repeat (10) @(posedge pci_clk);
    t_mode = 2'h1;
    req(1, agt_pkg::CMD_MEM_WR, 64'h88, 64'h2, 8'h01, 0);
    check("after reset", status, agt_pkg::ST_OK);
    check("after reset data", u_part.cap_data[31:0], 32'h2);
    $display("bus reset done");
  endtask : t_reset

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  // Main sequence after a 20-cycle reset
  initial begin
    {reset, start, wr, wide, bus_rst_n} = 5'b10000;
    {cmd, addr, wdata, be, t_mode} = '0;
    {errors, checks_done, serr_cnt, perr_cnt} = '0;
    flt = 64'h3C96_A55A_0FF0_C33C;
    prev_oe = '0;
    prev_v = '1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    bus_rst_n = 1'b1;
    repeat (10) @(negedge clk);
    t_mwr;
    t_mrd;
    t_mend;
    t_tgt;
    t_perr;
    t_reset;
    end_of_test;
  end

  // Watchdog, far beyond the few microseconds the tests need
  initial begin
    #100000;
    errors++;
    end_of_test;
  end
endmodule : test_pci_bus_agent_signalling
